// ===== shared/aemx_cfg.svh
// constants for the accumulator extract, field insert and word mac datapath
`ifndef AEMX_CFG_SVH
`define AEMX_CFG_SVH

// instruction word fields
`define AEMX_MAJOR_MSB       31
`define AEMX_MAJOR_LSB       26
`define AEMX_MAJOR_GROUP     6'h1f
`define AEMX_FUNC_MSB        5
`define AEMX_FUNC_LSB        0
`define AEMX_SUB_MSB         10
`define AEMX_SUB_LSB         6
`define AEMX_IDX_MSB         12
`define AEMX_IDX_LSB         11
`define AEMX_PAD_MSB         15
`define AEMX_PAD_LSB         13
`define AEMX_INS_ZERO_MSB    15
`define AEMX_INS_ZERO_LSB    6

// function codes
`define AEMX_FUNC_EXTRACT    6'h3c
`define AEMX_FUNC_INSERT     6'h0d
`define AEMX_FUNC_MAC        6'h34

// sub-operation codes
`define AEMX_SUB_EXT_PLAIN   5'h01
`define AEMX_SUB_EXT_ROUND   5'h05
`define AEMX_SUB_EXT_SAT     5'h07
`define AEMX_SUB_MAC_ADD     5'h19
`define AEMX_SUB_MAC_ADDU    5'h1d
`define AEMX_SUB_MAC_SUB     5'h1b

// control word fields
`define AEMX_POS_MSB         6
`define AEMX_POS_LSB         0
`define AEMX_SIZE_MSB        12
`define AEMX_SIZE_LSB        7
`define AEMX_STICKY_BIT      23

// extract and insert details
`define AEMX_SHIFT_MSB       5
`define AEMX_MSB_LIMIT       8'h3f
`define AEMX_SAT_POS         32'h7fffffff
`define AEMX_SAT_NEG         32'h80000000

`endif

// ===== shared/aemx_pkg.sv
// types shared by the accumulator extract, insert and mac datapath
package aemx_pkg;

  // decoded operation kinds
  typedef enum logic [2:0] {
    aemx_op_none     = 3'h0,
    aemx_op_ext      = 3'h1,
    aemx_op_ext_rnd  = 3'h3,
    aemx_op_ext_sat  = 3'h2,
    aemx_op_insert   = 3'h6,
    aemx_op_mac_add  = 3'h7,
    aemx_op_mac_addu = 3'h5,
    aemx_op_mac_sub  = 3'h4
  } aemx_op_t;

endpackage

// ===== rtl/aemx_lane_mul.sv
// one 32x32 multiplier lane, signed or unsigned, full 64-bit product
`timescale 1ns/100ps
module aemx_lane_mul #(
  parameter int WORD_W = 32
) (
  input  wire logic [WORD_W-1:0]   mul_a,       // first factor
  input  wire logic [WORD_W-1:0]   mul_b,       // second factor
  input  wire logic                signed_mode, // high: two's complement factors
  output logic      [2*WORD_W-1:0] product      // full-width product
);

  // one extra bit per factor lets a single signed multiplier serve both modes
  logic signed [WORD_W:0]     ext_a;  // factor a, extended by mode
  logic signed [WORD_W:0]     ext_b;  // factor b, extended by mode
  logic signed [2*WORD_W+1:0] wide;   // product before trimming

  // extend, multiply, keep the low 64 bits
  always_comb begin
    ext_a   = $signed({signed_mode & mul_a[WORD_W-1], mul_a});
    ext_b   = $signed({signed_mode & mul_b[WORD_W-1], mul_b});
    wide    = ext_a * ext_b;
    product = wide[2*WORD_W-1:0];
  end

endmodule // aemx_lane_mul

// ===== rtl/aemx_datapath.sv
// accumulator extract, variable field insert and two-lane word mac datapath
`timescale 1ns/100ps
`include "aemx_cfg.svh"

// Summary of operation
// [RL1] accumulator shifted arithmetically, sign fills high bits
// [RL2] shift amount is source operand bits 5..0
// [RL3] plain extract: low word, sign-extended, no sticky
// [RL4] result from shifted bits 32..1, bit 32 replicated
// [RL5] rounding extract adds one below result lsb
// [RL6] overflow when rounded bits 128..32 not uniform
// [RL7] saturating extract clamps to max or min word
// [RL8] rounding forms set sticky overflow bit 23
// [RL9] four accumulators; extracts leave accumulator unchanged
// [RL10] only reserved or disabled exceptions, nothing data-dependent
// [RL11] insert start bits 6..0, width bits 12..7
// [RL12] insert merges low source bits into target
// [RL13] bad insert field gives unpredictable target value
// [RL14] insert decoded from group and function, zero fields
// [RL15] before release 2, insert is reserved instruction
// [RL16] signed mac adds sign-extended lane products
// [RL17] unsigned mac adds zero-extended lane products
// [RL18] signed mac subtract removes sign-extended products
// [RL19] software saves accumulator zero around plain multiplies
// [RL20] operands in together; results and sticky strobe out
module aemx_datapath
  import aemx_pkg::*;
#(
  parameter int ACC_COUNT = 4,  // number of accumulators addressed
  parameter int DATA_W    = 64  // general register width
) (
  input  wire logic                 ref_clk,           // core clock
  input  wire logic                 reset_n,           // asynchronous reset, active low
  input  wire logic                 issue_valid,       // instruction presented this cycle
  input  wire logic [31:0]          instr_word,        // raw instruction word
  input  wire logic [DATA_W-1:0]    source_operand,    // source register value
  input  wire logic [DATA_W-1:0]    target_operand,    // target register value
  input  wire logic [DATA_W-1:0]    upper_half,        // selected accumulator, high half
  input  wire logic [DATA_W-1:0]    bottom_half,       // selected accumulator, low half
  input  wire logic [31:0]          signal_proc_control_word, // control word
  input  wire logic                 dsp_enable,        // signal processing unit enabled
  input  wire logic                 arch_release2,     // core is release 2 or later
  output logic                      result_valid,      // one-cycle result strobe
  output logic                      target_write,      // target register update
  output logic [DATA_W-1:0]         target_value,      // new target register value
  output logic                      acc_write,         // accumulator update
  output logic [1:0]                sum_register_index, // accumulator written
  output logic [DATA_W-1:0]         upper_half_out,    // new accumulator high half
  output logic [DATA_W-1:0]         bottom_half_out,   // new accumulator low half
  output logic                      sticky_set,        // set control word bit 23
  output logic                      reserved_instr_exc, // reserved instruction
  output logic                      dsp_disabled_exc   // unit disabled exception
);

  localparam int ACC_W  = 2 * DATA_W;
  localparam int WORD_W = DATA_W / 2;

  // the index field is two bits wide and the lanes split one register in two
  if (ACC_COUNT < 1 || ACC_COUNT > 4 || DATA_W != 64) begin : g_bad_cfg
    $error("aemx_datapath: ACC_COUNT must be 1..4 and DATA_W 64");
  end

  // decode used both for the operation and for the exception priority
  function automatic aemx_op_t decode_op(input logic [31:0] iw);
    aemx_op_t op;
    op = aemx_op_none;
    if (iw[`AEMX_MAJOR_MSB:`AEMX_MAJOR_LSB] == `AEMX_MAJOR_GROUP) begin
      case (iw[`AEMX_FUNC_MSB:`AEMX_FUNC_LSB])
        `AEMX_FUNC_EXTRACT: begin
          if (iw[`AEMX_PAD_MSB:`AEMX_PAD_LSB] == 3'h0) begin
            case (iw[`AEMX_SUB_MSB:`AEMX_SUB_LSB])
              `AEMX_SUB_EXT_PLAIN: op = aemx_op_ext;
              `AEMX_SUB_EXT_ROUND: op = aemx_op_ext_rnd;
              `AEMX_SUB_EXT_SAT:   op = aemx_op_ext_sat;
              default:             op = aemx_op_none;
            endcase
          end
        end
        `AEMX_FUNC_INSERT: begin
          // both five-bit fields below the target field must be zero
          if (iw[`AEMX_INS_ZERO_MSB:`AEMX_INS_ZERO_LSB] == 10'h000) begin
            op = aemx_op_insert; // RL14
          end
        end
        `AEMX_FUNC_MAC: begin
          if (iw[`AEMX_PAD_MSB:`AEMX_PAD_LSB] == 3'h0) begin
            case (iw[`AEMX_SUB_MSB:`AEMX_SUB_LSB])
              `AEMX_SUB_MAC_ADD:  op = aemx_op_mac_add;
              `AEMX_SUB_MAC_ADDU: op = aemx_op_mac_addu;
              `AEMX_SUB_MAC_SUB:  op = aemx_op_mac_sub;
              default:            op = aemx_op_none;
            endcase
          end
        end
        default: op = aemx_op_none;
      endcase
    end
    return op;
  endfunction

  // lane products from the two lane multipliers, one per word lane
  logic [WORD_W-1:0] lane_a [2];      // source operand words
  logic [WORD_W-1:0] lane_b [2];      // target operand words
  logic [DATA_W-1:0] lane_prod [2];   // 64-bit lane products
  logic              mul_signed;      // signed lane multiply

  // decoded on its own so the products do not loop back through the main process
  assign mul_signed = (decode_op(instr_word) != aemx_op_mac_addu); // RL16 RL17

  for (genvar ln = 0; ln < 2; ln++) begin : g_lane
    assign lane_a[ln] = source_operand[ln*WORD_W +: WORD_W];
    assign lane_b[ln] = target_operand[ln*WORD_W +: WORD_W];
    aemx_lane_mul #(.WORD_W(WORD_W)) u_mul (
      .mul_a       (lane_a[ln]),
      .mul_b       (lane_b[ln]),
      .signed_mode (mul_signed),
      .product     (lane_prod[ln])
    );
  end

  // next values of every registered output
  logic              next_result_valid;
  logic              next_target_write;
  logic [DATA_W-1:0] next_target_value;
  logic              next_acc_write;
  logic [1:0]        next_index;
  logic [DATA_W-1:0] next_upper;
  logic [DATA_W-1:0] next_bottom;
  logic              next_sticky;
  logic              next_rsv;
  logic              next_dis;

  // working values of the datapath
  aemx_op_t          op;           // decoded operation
  logic [ACC_W-1:0]  acc;          // selected accumulator
  logic [ACC_W:0]    shifted;      // 129-bit shifted intermediate
  logic [ACC_W:0]    rounded;      // shifted plus one at bit 0
  logic              ovf;          // rounded bits 128..32 not uniform
  logic [WORD_W-1:0] word_res;     // extracted word before sign extension
  logic [7:0]        fld_pos;      // insert start bit
  logic [7:0]        fld_size;     // insert width
  logic [7:0]        fld_msb;      // insert top bit
  logic [DATA_W-1:0] fld_mask;     // ones over the inserted field
  logic [ACC_W-1:0]  prod_ext [2]; // lane products widened to 128 bits
  logic [ACC_W-1:0]  acc_new;      // accumulator after mac

  // decode, execute and pick the results in one pass
  always_comb begin
    op                = decode_op(instr_word);
    acc               = {upper_half, bottom_half};
    next_result_valid = issue_valid;
    next_target_write = 1'b0;
    next_target_value = target_operand;
    next_acc_write    = 1'b0;
    next_index        = instr_word[`AEMX_IDX_MSB:`AEMX_IDX_LSB]; // RL9
    next_upper        = upper_half;
    next_bottom       = bottom_half;
    next_sticky       = 1'b0;
    next_rsv          = 1'b0;
    next_dis          = 1'b0;

    // an extra zero below the lsb keeps the most significant discarded bit
    shifted = ACC_W'(0) + 129'($signed({acc, 1'b0}) >>>
              source_operand[`AEMX_SHIFT_MSB:0]); // RL1 RL2
    rounded = shifted + 129'h1; // RL5
    // top 97 bits of the rounded value must be all zeros or all ones
    ovf = ~((rounded[ACC_W:WORD_W] == '0) || (rounded[ACC_W:WORD_W] == '1)); // RL6
    word_res = shifted[WORD_W:1]; // RL4

    // insert field geometry
    fld_pos  = {1'b0, signal_proc_control_word[`AEMX_POS_MSB:`AEMX_POS_LSB]}; // RL11
    fld_size = {2'h0, signal_proc_control_word[`AEMX_SIZE_MSB:`AEMX_SIZE_LSB]}; // RL11
    fld_msb  = fld_pos + fld_size - 8'h01; // RL11
    fld_mask = ((DATA_W'(1) << fld_size[5:0]) - DATA_W'(1)) << fld_pos[5:0];

    // lane products extended by signedness
    for (int i = 0; i < 2; i++) begin
      prod_ext[i] = mul_signed ? {{DATA_W{lane_prod[i][DATA_W-1]}}, lane_prod[i]}
                               : {{DATA_W{1'b0}}, lane_prod[i]}; // RL16 RL17
    end
    if (op == aemx_op_mac_sub) begin
      acc_new = acc - prod_ext[1] - prod_ext[0]; // RL18
    end else begin
      acc_new = acc + prod_ext[1] + prod_ext[0]; // RL16 RL17
    end

    if (!issue_valid) begin
      // idle cycle: hold results quiet
      next_result_valid = 1'b0;
    end else if (op == aemx_op_none ||
                 (op == aemx_op_insert && !arch_release2)) begin
      // unknown encoding, or insert on an older core
      next_rsv = 1'b1; // RL10 RL15
    end else if (!dsp_enable) begin
      // unit switched off: no state changes at all
      next_dis = 1'b1; // RL10
    end else begin
      // no path below raises anything that depends on the data
      case (op)
        aemx_op_ext: begin
          // plain form never touches the sticky bit
          next_target_write = 1'b1;
          next_target_value = {{WORD_W{word_res[WORD_W-1]}}, word_res}; // RL3
        end
        aemx_op_ext_rnd: begin
          word_res          = rounded[WORD_W:1]; // RL5
          next_target_write = 1'b1;
          next_target_value = {{WORD_W{word_res[WORD_W-1]}}, word_res}; // RL5
          next_sticky       = ovf; // RL8
        end
        aemx_op_ext_sat: begin
          word_res = rounded[WORD_W:1];
          if (ovf) begin
            word_res = rounded[ACC_W] ? `AEMX_SAT_NEG : `AEMX_SAT_POS; // RL7
          end
          next_target_write = 1'b1;
          next_target_value = {{WORD_W{word_res[WORD_W-1]}}, word_res}; // RL7
          next_sticky       = ovf; // RL8
        end
        aemx_op_insert: begin
          next_target_write = 1'b1;
          if (fld_pos > fld_msb || fld_msb > `AEMX_MSB_LIMIT) begin
            // any value is allowed; the target is simply rewritten unchanged
            next_target_value = target_operand; // RL13
          end else begin
            next_target_value = (target_operand & ~fld_mask) |
                                ((source_operand << fld_pos[5:0]) & fld_mask); // RL12
          end
        end
        aemx_op_mac_add, aemx_op_mac_addu, aemx_op_mac_sub: begin
          // indexes beyond the configured count are treated as reserved
          if (32'(next_index) >= ACC_COUNT) begin
            next_rsv = 1'b1;
          end else begin
            next_acc_write = 1'b1; // RL20
            next_upper     = acc_new[ACC_W-1:DATA_W];
            next_bottom    = acc_new[DATA_W-1:0];
          end
        end
        default: begin
          next_rsv = 1'b1;
        end
      endcase
    end
  end

  // register every output so the pipeline sees one clean result stage
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      result_valid       <= 1'b0;
      target_write       <= 1'b0;
      target_value       <= '0;
      acc_write          <= 1'b0;
      sum_register_index <= 2'h0;
      upper_half_out     <= '0;
      bottom_half_out    <= '0;
      sticky_set         <= 1'b0;
      reserved_instr_exc <= 1'b0;
      dsp_disabled_exc   <= 1'b0;
    end else begin
      result_valid       <= next_result_valid; // RL20
      target_write       <= next_target_write;
      target_value       <= next_target_value;
      acc_write          <= next_acc_write; // RL9
      sum_register_index <= next_index;
      upper_half_out     <= next_upper;
      bottom_half_out    <= next_bottom;
      sticky_set         <= next_sticky; // RL8
      reserved_instr_exc <= next_rsv;
      dsp_disabled_exc   <= next_dis;
    end
  end

endmodule // aemx_datapath

// ===== tb/aemx_datapath_chk.sv
// timing and exception checks on the datapath ports
`timescale 1ns/100ps
module aemx_datapath_chk (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        issue_valid,
  input wire logic [31:0] instr_word,
  input wire logic        dsp_enable,
  input wire logic        arch_release2,
  input wire logic        result_valid,
  input wire logic        target_write,
  input wire logic        acc_write,
  input wire logic [1:0]  sum_register_index,
  input wire logic        sticky_set,
  input wire logic        reserved_instr_exc,
  input wire logic        dsp_disabled_exc
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // an op taken on this edge, and an extract among them
  sequence took_s; issue_valid; endsequence
  sequence ext_s; issue_valid && instr_word[5:0] == 6'h3c; endsequence
  answer_now_a: assert property (took_s |=> result_valid)
    else $error("no result one cycle after issue");
  idle_quiet_a: assert property (!issue_valid
    |=> !result_valid && !target_write && !acc_write)
    else $error("output pulse without an issue");
  ext_keeps_acc_a: assert property (ext_s |=> !acc_write)
    else $error("extract wrote an accumulator");
  acc_index_a: assert property (acc_write
    |-> sum_register_index == $past(instr_word[12:11]))
    else $error("accumulator index differs from the op");
  exc_no_write_a: assert property ((reserved_instr_exc || dsp_disabled_exc)
    |-> !target_write && !acc_write && !sticky_set)
    else $error("exception op still wrote");
  exc_single_a: assert property (issue_valid && !dsp_enable
    |=> reserved_instr_exc != dsp_disabled_exc)
    else $error("disabled unit did not raise exactly one exception");
  sticky_round_a: assert property (sticky_set
    |-> $past(instr_word[8]) && $past(instr_word[5:0]) == 6'h3c && target_write)
    else $error("sticky pulse from a non-rounding op");
  bad_group_a: assert property (issue_valid && instr_word[31:26] != 6'h1f
    |=> reserved_instr_exc)
    else $error("foreign opcode group not refused");
  old_release_a: assert property (issue_valid && !arch_release2
    && instr_word[5:0] == 6'h0d |=> reserved_instr_exc)
    else $error("insert accepted on an old release");
endmodule // aemx_datapath_chk

// ===== tb/aemx_pipe_model.sv
// pipeline stand-in: four accumulator pairs with write-back from the datapath
`timescale 1ns/100ps
module aemx_pipe_model (
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic [31:0]  instr_word,      // index taken from bits 12..11
  input  wire logic         load,            // preload the addressed pair
  input  wire logic [127:0] load_val,        // preload value
  input  wire logic         acc_write,       // write-back strobe
  input  wire logic [1:0]   sum_register_index,
  input  wire logic [63:0]  upper_half_out,
  input  wire logic [63:0]  bottom_half_out,
  output logic      [63:0]  upper_half,
  output logic      [63:0]  bottom_half
);
  logic [127:0] acc [4]; // pair 0 is the legacy high/low pair
  // only the addressed pair changes, so pairs 1..3 survive other ops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) acc <= '{default: '0};
    else if (acc_write) acc[sum_register_index] <= {upper_half_out, bottom_half_out};
    else if (load) acc[instr_word[12:11]] <= load_val;
  end
  // the selected pair is presented with the op, no forwarding
  assign {upper_half, bottom_half} = acc[instr_word[12:11]];
endmodule // aemx_pipe_model

// ===== tb/aemx_datapath_bench.sv
// random and corner-case bench for the extract, insert and mac datapath
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR %0t value mismatch", $time); end end
module aemx_datapath_bench;
  typedef struct {logic [63:0] tv; logic [127:0] acc; logic st, tw, aw;} aemx_exp_t;
  logic ref_clk = 0, reset_n = 0, issue_valid = 0, dsp_enable = 1, arch_release2 = 1;
  logic [31:0] instr_word = 0, signal_proc_control_word = 0;
  logic [63:0] source_operand = 0, target_operand = 0, upper_half, bottom_half;
  logic load = 0;
  logic [127:0] load_val = 0;
  logic result_valid, target_write, acc_write, sticky_set, reserved_instr_exc, dsp_disabled_exc;
  logic [63:0] target_value, upper_half_out, bottom_half_out;
  logic [1:0] sum_register_index;
  int mismatches = 0, check_count = 0, cycles = 0;
  // {sub-op, function} of the seven ops
  logic [10:0] codes [7] = '{{5'h01, 6'h3c}, {5'h05, 6'h3c}, {5'h07, 6'h3c}, {5'h00, 6'h0d},
                             {5'h19, 6'h34}, {5'h1d, 6'h34}, {5'h1b, 6'h34}};
  aemx_datapath aemx_datapath_i (.ref_clk, .reset_n, .issue_valid, .instr_word,
    .source_operand, .target_operand, .upper_half, .bottom_half,
    .signal_proc_control_word, .dsp_enable, .arch_release2, .result_valid,
    .target_write, .target_value, .acc_write, .sum_register_index,
    .upper_half_out, .bottom_half_out, .sticky_set, .reserved_instr_exc,
    .dsp_disabled_exc);
  aemx_pipe_model aemx_pipe_model_i (.ref_clk, .reset_n, .instr_word, .load, .load_val,
    .acc_write, .sum_register_index, .upper_half_out, .bottom_half_out,
    .upper_half, .bottom_half);
  always #5 ref_clk = ~ref_clk;
  // insert has no index field, so bits 12..11 stay zero there
  function automatic logic [31:0] wd(int k, logic [1:0] idx);
    return {6'h1f, 13'h0, (k == 3) ? 2'b00 : idx, codes[k]};
  endfunction
  // reference result worked out bit by bit
  function automatic aemx_exp_t calc(logic [31:0] w, logic [63:0] s, t, h, l, logic [31:0] c);
    aemx_exp_t e;
    logic [128:0] x;
    logic [127:0] p1, p0;
    logic [63:0] mk;
    logic [7:0] m;
    logic ov;
    e = '{t, {h, l}, 1'b0, 1'b0, 1'b0};
    x = $signed({h, l, 1'b0}) >>> s[5:0];
    if (w[8]) x = x + 1;
    ov = !(&x[128:32] || !(|x[128:32]));
    case (w[5:0])
      6'h3c: begin
        e.tw = 1'b1;
        e.st = w[8] & ov;
        e.tv = {{32{x[32]}}, x[32:1]};
        if (w[7] && ov) e.tv = x[128] ? 64'hffffffff80000000 : 64'h7fffffff;
      end
      6'h0d: begin
        e.tw = 1'b1;
        m = {1'b0, c[6:0]} + c[12:7] - 8'h01;
        mk = (64'h1 << c[12:7]) - 64'h1;
        if (c[12:7] != 0 && m < 8'h40) e.tv = (t & ~(mk << c[6:0])) | ((s & mk) << c[6:0]);
      end
      6'h34: begin
        e.aw = 1'b1;
        if (w[8]) begin
          p1 = s[63:32] * t[63:32];
          p0 = s[31:0] * t[31:0];
        end else begin
          p1 = $signed(s[63:32]) * $signed(t[63:32]);
          p0 = $signed(s[31:0]) * $signed(t[31:0]);
        end
        e.acc = w[7] ? {h, l} - p1 - p0 : {h, l} + p1 + p0;
      end
      default: ;
    endcase
    return e;
  endfunction
  // optional preload cycle, one issue, then the answer one edge later
  task automatic op(logic [31:0] w, logic [63:0] a, b, logic [31:0] c, logic ld, logic [127:0] lv);
    aemx_exp_t e;
    logic ex;
    @(posedge ref_clk);
    // mode pins set just before the call have landed by this edge
    ex = w[31:26] != 6'h1f ||
         (w[5:0] == 6'h0d ? (w[15:6] != 0 || !arch_release2) : w[15:13] != 0);
    instr_word <= w;
    load <= ld;
    load_val <= lv;
    @(posedge ref_clk);
    load <= 1'b0;
    issue_valid <= 1'b1;
    source_operand <= a;
    target_operand <= b;
    signal_proc_control_word <= c;
    #1 e = calc(w, a, b, upper_half, bottom_half, c);
    @(posedge ref_clk);
    issue_valid <= 1'b0;
    #1 `CHK(result_valid, 1'b1)
    if (ex || !dsp_enable) begin
      `CHK({reserved_instr_exc, dsp_disabled_exc, target_write, acc_write}, {ex, !ex, 2'b00})
    end else begin
      `CHK({target_write, acc_write, sticky_set}, {e.tw, e.aw, e.st})
      `CHK(target_value, e.tv)
      `CHK({upper_half_out, bottom_half_out}, e.acc)
      if (e.aw) `CHK(sum_register_index, w[12:11])
    end
  endtask
  function automatic logic [63:0] r64();
    return {$urandom, $urandom};
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hang guard: far above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    void'($urandom(32'h0aadf9dc));
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    // outputs still hold their reset values at the release edge
    `CHK({result_valid, target_write, acc_write, sticky_set}, 4'h0)
    for (int k = 0; k < 7; k++) for (int j = 0; j < 4; j++)
      op(wd(k, 2'(j)), r64(), r64(), $urandom, 1'b1, {r64(), r64()});
    for (int k = 0; k < 3; k++) // rounding carry into overflow, high shift bits ignored
      op(wd(k, 2'h1), 64'hffffffffffffffc8, 64'h0, 32'h0, 1'b1, 128'h7fffffff80);
    op(wd(3, 2'h0), r64(), r64(), {19'h0, 6'd4, 7'd60}, 1'b0, 128'h0);
    op(wd(3, 2'h0), r64(), r64(), {19'h0, 6'd5, 7'd60}, 1'b0, 128'h0);
    op(wd(3, 2'h0), r64(), r64(), {19'h0, 6'd0, 7'd3}, 1'b0, 128'h0);
    op(wd(3, 2'h0) | 32'h40, r64(), r64(), 32'h0, 1'b0, 128'h0);
    op(wd(4, 2'h2) ^ 32'h80000000, r64(), r64(), 32'h0, 1'b0, 128'h0);
    op(wd(5, 2'h1) | 32'h2000, r64(), r64(), 32'h0, 1'b0, 128'h0);
    dsp_enable <= 1'b0;
    op(wd(6, 2'h2), r64(), r64(), 32'h0, 1'b0, 128'h0);
    arch_release2 <= 1'b0;
    op(wd(3, 2'h0), r64(), r64(), 32'h0, 1'b0, 128'h0);
    dsp_enable <= 1'b1;
    op(wd(3, 2'h0), r64(), r64(), 32'h0, 1'b0, 128'h0);
    op(wd(2, 2'h3), r64(), r64(), 32'h0, 1'b1, {r64(), r64()});
    arch_release2 <= 1'b1;
    for (int i = 0; i < 80; i++) // chained macs when no preload
      op(wd(int'($urandom % 7), 2'($urandom)), r64(), r64(), $urandom, 1'($urandom),
         {r64(), r64()});
    test_done();
  end
endmodule // aemx_datapath_bench
bind aemx_datapath aemx_datapath_chk aemx_datapath_chk_i (.ref_clk, .reset_n, .issue_valid,
  .instr_word, .dsp_enable, .arch_release2, .result_valid, .target_write, .acc_write,
  .sum_register_index, .sticky_set, .reserved_instr_exc, .dsp_disabled_exc);
